// ==== rtl/abtc_regs.vh ====
`ifndef ABTC_REGS_VH
`define ABTC_REGS_VH
// torque limit range in percent of rated torque
`define ABTC_TRQ_MIN       11'h001
`define ABTC_TRQ_MAX       11'h3E8
`define ABTC_TRQ_W         11
// torque source select codes
`define ABTC_SRC_BLOCK     2'h0
`define ABTC_SRC_PROG      2'h1
`define ABTC_SRC_CHANGE    2'h2
// move kinds
`define ABTC_MOVE_POS      2'h0
`define ABTC_MOVE_JOG      2'h1
`define ABTC_MOVE_HWHEEL   2'h2
// instruction kinds; home and simultaneous forbid cancelling
`define ABTC_INS_NORMAL    2'h0
`define ABTC_INS_HOME      2'h1
`define ABTC_INS_SIMUL     2'h2
// cancel source selects
`define ABTC_CSRC_X        3'h0
`define ABTC_CSRC_Y        3'h1
`define ABTC_CSRC_M        3'h2
`define ABTC_CSRC_B        3'h3
`define ABTC_CSRC_F        3'h4
// backlash amount width in pulses
`define ABTC_BL_W          16
`endif

// ==== rtl/abtc_sync3.v ====
`timescale 1ns/1ns
// three-stage synchroniser; output changes when stages two and three agree
module abtc_sync3 (
  input  wire sys_clk,
  input  wire srst,
  input  wire din,
  output reg  dout
);
  reg s1;
  reg s2;
  reg s3;
  // shift chain and agreement filter
  always @(posedge sys_clk) begin
    if (srst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // abtc_sync3

// ==== rtl/abtc_trq_clamp.v ====
`timescale 1ns/1ns
`include "abtc_regs.vh"
// clamps a demanded torque to a limit, both in percent of rated torque
module abtc_trq_clamp #(
  parameter W = `ABTC_TRQ_W
) (
  input  wire [W-1:0] demand,
  input  wire [W-1:0] limit,
  output wire [W-1:0] result
);
  // pass the smaller of the two
  assign result = (demand > limit) ? limit : demand;
endmodule // abtc_trq_clamp

// ==== rtl/axis_backlash_torque_cancel.v ====
`timescale 1ns/1ns
`include "abtc_regs.vh"
// Summary of operation
// - first start, home direction: no compensation
// - first start, other direction: compensate
// - jog start reversal: compensate
// - positioning or handwheel reversal: compensate
// - compensate after home return completes
// - absolute mode saves, restores direction state
// - compensation pulses added to feed value
// - new amount used only after home return or reset
// - torque limit accepted from 1 to 1000
// - demanded torque clamped to active limit while running
// - limit from selected parameter block
// - program's own limit while it runs
// - change request replaces active limit
// - start rejected while external stop asserted
// - skip request lets start bypass stop
// - cancel during run: decelerate and stop
// - cancel selectable from five device kinds
// - no cancel for home or simultaneous start
// - cancel-then-start ignores follow-on program
module axis_backlash_torque_cancel #(
  parameter BLW = `ABTC_BL_W,
  parameter TW  = `ABTC_TRQ_W,
  parameter FW  = 32
) (
  input  wire            sys_clk,
  input  wire            srst,
  input  wire            start_req,
  input  wire [1:0]      move_kind,
  input  wire [1:0]      instr_kind,
  input  wire            move_dir,
  input  wire            feed_pulse,
  input  wire            home_dir,
  input  wire            home_done,
  input  wire            abs_mode,
  input  wire            power_off,
  input  wire            saved_dir_valid,
  input  wire            saved_dir,
  input  wire [BLW-1:0]  bl_amount_cfg,
  input  wire [TW-1:0]   trq_block,
  input  wire            prog_trq_valid,
  input  wire [TW-1:0]   trq_prog,
  input  wire            torque_limit_change_request,
  input  wire [TW-1:0]   trq_change,
  input  wire [TW-1:0]   trq_demand,
  input  wire            ext_stop_pin,
  input  wire            stop_skip_request,
  input  wire            cancel_enable,
  input  wire            cancel_then_start,
  input  wire [2:0]      cancel_src_sel,
  input  wire [4:0]      cancel_src,
  input  wire            move_done,
  output reg             start_ok,
  output reg             start_err,
  output reg             running,
  output reg             decel_stop,
  output reg             follow_on_ignored,
  output reg             comp_pulse,
  output reg             comp_busy,
  output reg             feed_out,
  output reg             feed_dir,
  output reg  [FW-1:0]   feed_value,
  output reg  [TW-1:0]   trq_active,
  output reg  [TW-1:0]   trq_out,
  output reg             trq_set_err,
  output reg             save_dir_valid,
  output reg             save_dir
);
  reg            ext_stop_sync;
  reg            last_dir;
  reg            dir_known;
  reg [BLW-1:0]  bl_amount;
  reg [BLW-1:0]  comp_cnt;
  reg            pend_start;
  reg            pend_dir;
  reg            skip_armed;
  reg            cancel_armed;
  reg            cts_armed;
  reg            cancel_sel;
  reg            need_comp;
  reg [TW-1:0]   next_trq;
  reg            next_trq_err;
  reg [FW-1:0]   next_feed_value;
  wire [TW-1:0]  clamped;
  wire           start_take;

  // a start is taken only when nothing else owns the axis
  assign start_take = start_req && !running && !comp_busy && !home_done;

  // external stop pin into the clock domain
  // three stages keep a pin glitch from refusing a start
  abtc_sync3 u_stop_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     (ext_stop_pin),
    .dout    (ext_stop_sync)
  );

  abtc_trq_clamp #(.W(TW)) u_clamp (
    .demand (trq_demand),
    .limit  (trq_active),
    .result (clamped)
  );

  // cancel source multiplexer
  always @* begin
    case (cancel_src_sel)
      `ABTC_CSRC_X: cancel_sel = cancel_src[0];
      `ABTC_CSRC_Y: cancel_sel = cancel_src[1];
      `ABTC_CSRC_M: cancel_sel = cancel_src[2];
      `ABTC_CSRC_B: cancel_sel = cancel_src[3];
      `ABTC_CSRC_F: cancel_sel = cancel_src[4];
      default:      cancel_sel = 1'b0;
    endcase
  end

  // compensation decision for a new start
  always @* begin
    need_comp = 1'b0;
    if (!dir_known) begin
      need_comp = (move_dir != home_dir);
    end else begin
      need_comp = (move_dir != last_dir);
    end
  end

  // one feed step in the present feed direction
  always @* begin
    if (feed_dir) begin
      next_feed_value = feed_value - {{(FW-1){1'b0}}, 1'b1};
    end else begin
      next_feed_value = feed_value + {{(FW-1){1'b0}}, 1'b1};
    end
  end

  // torque limit selection and range check
  always @* begin
    next_trq     = trq_active;
    next_trq_err = 1'b0;
    if (torque_limit_change_request) begin
      next_trq = trq_change;
    end else if (start_take) begin
      next_trq = prog_trq_valid ? trq_prog : trq_block;
    end
    if (next_trq < `ABTC_TRQ_MIN || next_trq > `ABTC_TRQ_MAX) begin
      next_trq     = trq_active;
      next_trq_err = torque_limit_change_request || start_take;
    end
  end

  // torque limit register and clamped output
  always @(posedge sys_clk) begin
    if (srst) begin
      // the limit starts at the top of the range
      trq_active  <= `ABTC_TRQ_MAX;
      trq_out     <= {TW{1'b0}};
      trq_set_err <= 1'b0;
    end else begin
      trq_active  <= next_trq;
      trq_set_err <= next_trq_err;
      trq_out     <= running ? clamped : trq_demand;
    end
  end

  // start, cancel, backlash and feed sequencing
  always @(posedge sys_clk) begin
    if (srst) begin
      start_ok          <= 1'b0;
      start_err         <= 1'b0;
      running           <= 1'b0;
      decel_stop        <= 1'b0;
      follow_on_ignored <= 1'b0;
      comp_pulse        <= 1'b0;
      comp_busy         <= 1'b0;
      feed_out          <= 1'b0;
      feed_dir          <= 1'b0;
      feed_value        <= {FW{1'b0}};
      save_dir_valid    <= 1'b0;
      save_dir          <= 1'b0;
      last_dir          <= 1'b0;
      dir_known         <= 1'b0;
      // power-on amount so the first start can compensate
      bl_amount         <= bl_amount_cfg;
      comp_cnt          <= {BLW{1'b0}};
      pend_start        <= 1'b0;
      pend_dir          <= 1'b0;
      skip_armed        <= 1'b0;
      cancel_armed      <= 1'b0;
      cts_armed         <= 1'b0;
    end else begin
      start_ok          <= 1'b0;
      start_err         <= 1'b0;
      decel_stop        <= 1'b0;
      follow_on_ignored <= 1'b0;
      comp_pulse        <= 1'b0;
      feed_out          <= 1'b0;
      if (stop_skip_request) begin
        skip_armed <= 1'b1;
      end
      // restore saved direction in absolute mode
      if (abs_mode && saved_dir_valid && !dir_known) begin
        last_dir  <= saved_dir;
        dir_known <= 1'b1;
      end
      // store direction state at power off
      if (power_off && abs_mode) begin
        save_dir_valid <= dir_known;
        save_dir       <= last_dir;
      end
      if (home_done) begin
        // adopt new amount at home return
        bl_amount <= bl_amount_cfg;
        if (bl_amount_cfg != {BLW{1'b0}}) begin
          comp_cnt  <= bl_amount_cfg;
          comp_busy <= 1'b1;
          feed_dir  <= ~home_dir;
        end
        last_dir  <= ~home_dir;
        dir_known <= 1'b1;
      end else if (comp_busy) begin
        comp_pulse <= 1'b1;
        feed_out   <= 1'b1;
        feed_value <= next_feed_value;
        comp_cnt   <= comp_cnt - {{(BLW-1){1'b0}}, 1'b1};
        if (comp_cnt == {{(BLW-1){1'b0}}, 1'b1}) begin
          comp_busy <= 1'b0;
          if (pend_start) begin
            pend_start <= 1'b0;
            running    <= 1'b1;
          end
        end
      end else if (running) begin
        if (cancel_armed && cancel_sel) begin
          running    <= 1'b0;
          decel_stop <= 1'b1;
          follow_on_ignored <= cts_armed;
        end else if (move_done) begin
          running <= 1'b0;
        end else if (feed_pulse) begin
          feed_out   <= 1'b1;
          feed_value <= next_feed_value;
        end
        // cancel, completion or a feed pulse in this cycle go first
        if (!(cancel_armed && cancel_sel) && !move_done && !feed_pulse) begin
          // handwheel moves may reverse at any time
          if (move_kind == `ABTC_MOVE_HWHEEL && move_dir != last_dir
              && bl_amount != {BLW{1'b0}}) begin
            comp_cnt   <= bl_amount;
            comp_busy  <= 1'b1;
            feed_dir   <= move_dir;
            last_dir   <= move_dir;
            pend_start <= 1'b1;
            running    <= 1'b0;
          end else if (move_kind == `ABTC_MOVE_HWHEEL) begin
            last_dir <= move_dir;
            feed_dir <= move_dir;
          end
        end
      end else if (start_req) begin
        if (ext_stop_sync && !skip_armed) begin
          start_err <= 1'b1;
        end else begin
          skip_armed   <= 1'b0;
          start_ok     <= 1'b1;
          // no cancel for home or simultaneous
          cancel_armed <= cancel_enable && (instr_kind == `ABTC_INS_NORMAL);
          cts_armed    <= cancel_then_start;
          feed_dir     <= move_dir;
          last_dir     <= move_dir;
          dir_known    <= 1'b1;
          if (need_comp && bl_amount != {BLW{1'b0}}) begin
            comp_cnt   <= bl_amount;
            comp_busy  <= 1'b1;
            pend_start <= 1'b1;
          end else begin
            running <= 1'b1;
          end
        end
      end
    end
  end
endmodule // axis_backlash_torque_cancel

// ==== verification/abtc_checker.sv ====
`timescale 1ns/1ns
// ties the block's outputs to their causes
module abtc_checker (
  input wire        sys_clk,
  input wire        srst,
  input wire        start_req,
  input wire        torque_limit_change_request,
  input wire        start_err,
  input wire        running,
  input wire        decel_stop,
  input wire        follow_on_ignored,
  input wire        comp_pulse,
  input wire        feed_out,
  input wire [31:0] feed_value,
  input wire [10:0] trq_active,
  input wire [10:0] trq_out,
  input wire        trq_set_err
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_err; start_err |-> $past(start_req) && !running; endproperty
  a_err: assert property (p_err) else $error("refusal without start");
  property p_dec; decel_stop |-> !running && $past(running); endproperty
  a_dec: assert property (p_dec) else $error("stop while idle");
  property p_fol; follow_on_ignored |-> decel_stop; endproperty
  a_fol: assert property (p_fol) else $error("follow-on flag alone");
  property p_clp; $past(running) && $stable(trq_active) |-> trq_out <= trq_active; endproperty
  a_clp: assert property (p_clp) else $error("torque above limit");
  property p_rng; trq_active >= 11'h001 && trq_active <= 11'h3E8; endproperty
  a_rng: assert property (p_rng) else $error("limit out of range");
  property p_stp; $changed(feed_value) && !$past(srst) |-> (feed_out || $past(feed_out))
    && feed_value - $past(feed_value) + 32'h0000_0001 <= 32'h0000_0002; endproperty
  a_stp: assert property (p_stp) else $error("feed value jump");
  property p_cmp; comp_pulse |-> feed_out; endproperty
  a_cmp: assert property (p_cmp) else $error("burst pulse not fed");
  property p_set; trq_set_err |-> $past(torque_limit_change_request || start_req)
    && $stable(trq_active);
  endproperty
  a_set: assert property (p_set) else $error("bad limit handling");
endmodule // abtc_checker

bind axis_backlash_torque_cancel abtc_checker chk (
  .sys_clk                     (sys_clk),
  .srst                        (srst),
  .start_req                   (start_req),
  .torque_limit_change_request (torque_limit_change_request),
  .start_err                   (start_err),
  .running                     (running),
  .decel_stop                  (decel_stop),
  .follow_on_ignored           (follow_on_ignored),
  .comp_pulse                  (comp_pulse),
  .feed_out                    (feed_out),
  .feed_value                  (feed_value),
  .trq_active                  (trq_active),
  .trq_out                     (trq_out),
  .trq_set_err                 (trq_set_err)
);

// ==== verification/abtc_servo_model.sv ====
`timescale 1ns/1ns
// amplifier stand-in: follows pulses, reports torque demand
module abtc_servo_model (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire        feed_out,
  input  wire        feed_dir,
  output reg  [10:0] trq_demand,
  output integer     position
);
  integer     seed = 85838;
  reg  [31:0] r;
  initial trq_demand = 11'h000;
  initial position = 0;
  // count pulses by direction; demand wanders past the limit range
  always @(posedge sys_clk) begin
    r = $random(seed);
    trq_demand <= r[10:0];
    if (srst)
      position <= 0;
    else if (feed_out)
      position <= feed_dir ? position - 1 : position + 1;
  end
endmodule // abtc_servo_model

// ==== verification/axis_backlash_torque_cancel_bench.sv ====
`timescale 1ns/1ns
// moves, cancels, stop bypass and limit changes
module axis_backlash_torque_cancel_bench;
  reg         sys_clk = 0, srst = 1, start_req = 0, move_dir = 0, feed_pulse = 0;
  reg         home_dir = 0, home_done = 0, abs_mode = 0, power_off = 0, move_done = 0;
  reg         saved_dir_valid = 0, saved_dir = 0, prog_trq_valid = 0, ext_stop_pin = 0;
  reg         torque_limit_change_request = 0, stop_skip_request = 0;
  reg         cancel_enable = 0, cancel_then_start = 0, last_dir, known, ok, err;
  reg  [1:0]  move_kind = 0, instr_kind = 0;
  reg  [2:0]  cancel_src_sel = 0;
  reg  [4:0]  cancel_src = 0;
  reg  [15:0] bl_amount_cfg = 16'h0005;
  reg  [10:0] trq_block = 11'h0320, trq_prog = 11'h0100, trq_change = 11'h000, v, lim;
  reg  [31:0] r;
  wire        start_ok, start_err, running, decel_stop, follow_on_ignored, comp_pulse;
  wire        comp_busy, feed_out, feed_dir, trq_set_err, save_dir_valid, save_dir;
  wire [31:0] feed_value;
  wire [10:0] trq_active, trq_out, trq_demand;
  integer     seed = 85838, num_errors = 0, samples_checked = 0, cyc = 0;
  integer     position, ncomp, nb, amt, e, i, j;

  axis_backlash_torque_cancel dut (.*);
  abtc_servo_model amp (.*);

  always #5 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end

  task check(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
      end
    end
  endtask

  task complete_run;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // expected burst length for a start in direction d
  function integer expc(input d);
    expc = (known ? d != last_dir : d != home_dir) ? amt : 0;
  endfunction

  // demanded torque limited to the active limit
  function [10:0] clampx(input [10:0] dm, input [10:0] lm);
    clampx = dm > lm ? lm : dm;
  endfunction

  // start a move, count burst pulses, end it unless held
  task move(input [1:0] k, input d, input h);
    begin
      @(posedge sys_clk);
      move_kind <= k;
      move_dir <= d;
      prog_trq_valid <= ^$random(seed);
      start_req <= 1;
      @(posedge sys_clk);
      start_req <= 0;
      {ok, err, ncomp, nb} = 0;
      for (i = 0; i < 40 && running !== 1'b1; i = i + 1) begin
        @(posedge sys_clk);
        ok = ok | start_ok;
        err = err | start_err;
        ncomp = ncomp + comp_pulse;
        nb = nb + comp_busy;
      end
      if (ok) begin
        check(trq_active, prog_trq_valid ? trq_prog : trq_block);
        check(feed_dir, d);
        last_dir = d;
        known = 1;
      end
      if (!h) begin
        v = trq_demand;
        feed_pulse <= 1;
        @(posedge sys_clk);
        check(trq_out, ok ? clampx(v, prog_trq_valid ? trq_prog : trq_block) : v);
        feed_pulse <= 0;
        move_done <= 1;
        @(posedge sys_clk);
        move_done <= 0;
      end
    end
  endtask

  initial begin
    {last_dir, known, amt, lim} = {2'b00, 32'd5, 11'h3E8};
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    @(posedge sys_clk);
    check(trq_active, lim);
    for (j = 0; j < 8; j = j + 1) begin
      r = $random(seed);
      v = j[2] ? r[10:0] : (j[1] ? 11'h3E6 : 11'h000) + j[1:0];
      @(posedge sys_clk);
      trq_change <= v;
      torque_limit_change_request <= 1;
      @(posedge sys_clk);
      torque_limit_change_request <= 0;
      @(posedge sys_clk);
      err = trq_set_err;
      repeat (2) @(posedge sys_clk);
      if (v != 0 && v <= 11'h3E8)
        lim = v;
      check(trq_active, lim);
      check(err, v == 0 || v > 11'h3E8);
    end
    for (j = 0; j < 12; j = j + 1) begin
      r = $random(seed);
      e = expc(j ? r[0] : home_dir);
      move(j % 3, j ? r[0] : home_dir, 0);
      check(ncomp, e);
      check(nb, e);
    end
    e = amt;
    move(2, last_dir, 1);
    move_dir <= !last_dir;
    ncomp = 0;
    repeat (12) @(posedge sys_clk) ncomp = ncomp + comp_pulse;
    check(ncomp, e);
    check(running, 1);
    last_dir = !last_dir;
    move_done <= 1;
    @(posedge sys_clk);
    move_done <= 0;
    bl_amount_cfg <= 16'h0003;
    e = expc(!last_dir);
    move(0, !last_dir, 0);
    check(ncomp, e);
    @(posedge sys_clk);
    home_done <= 1;
    @(posedge sys_clk);
    home_done <= 0;
    ncomp = 0;
    repeat (30) @(posedge sys_clk) ncomp = ncomp + comp_pulse;
    check(ncomp, 3);
    {amt, last_dir} = {32'd3, !home_dir};
    e = expc(home_dir);
    move(1, home_dir, 0);
    check(ncomp, e);
    abs_mode <= 1;
    power_off <= 1;
    @(posedge sys_clk);
    power_off <= 0;
    repeat (2) @(posedge sys_clk);
    check(save_dir_valid, 1);
    check(save_dir, last_dir);
    for (j = 0; j < 7; j = j + 1) begin
      cancel_enable <= 1;
      cancel_then_start <= j[0];
      cancel_src_sel <= j % 5;
      instr_kind <= j > 4 ? j - 4 : 0;
      move(0, last_dir, 1);
      cancel_src <= 5'h01 << (j % 5);
      {ok, err} = 0;
      repeat (4) @(posedge sys_clk) {ok, err} = {ok, err} | {decel_stop, follow_on_ignored};
      check(ok, j < 5);
      check(err, j[0] && j < 5);
      cancel_src <= 0;
      move_done <= 1;
      @(posedge sys_clk);
      move_done <= 0;
    end
    instr_kind <= 0;
    ext_stop_pin <= 1;
    repeat (6) @(posedge sys_clk);
    move(0, last_dir, 0);
    check(err, 1);
    stop_skip_request <= 1;
    @(posedge sys_clk);
    stop_skip_request <= 0;
    move(0, last_dir, 0);
    check(ok, 1);
    ext_stop_pin <= 0;
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    known = 0;
    e = expc(!home_dir);
    move(2, !home_dir, 0);
    check(ncomp, e);
    repeat (2) @(posedge sys_clk);
    check(feed_value, position);
    saved_dir <= !home_dir;
    saved_dir_valid <= 1;
    srst <= 1;
    repeat (2) @(posedge sys_clk);
    srst <= 0;
    {known, last_dir} = {1'b1, !home_dir};
    e = expc(home_dir);
    move(0, home_dir, 0);
    check(ncomp, e);
    complete_run;
  end
endmodule // axis_backlash_torque_cancel_bench
